//--- cten_pkg.sv
// Package with register map, field layout and constants of the core timer block
package cten_pkg;

	// ========================================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] CTEN_OFF_CONTROL = 8'h00;
	localparam logic [7:0] CTEN_OFF_COUNT = 8'h04;
	localparam logic [7:0] CTEN_OFF_AUX = 8'h08;

	// ========================================================================
	// Control register field positions
	localparam int CTEN_POS_INSEL = 0;
	localparam int CTEN_POS_MODE = 3;
	localparam int CTEN_POS_RUN = 6;
	localparam int CTEN_POS_SWDIR = 7;
	localparam int CTEN_POS_EXTDIR = 8;
	localparam int CTEN_POS_OUTEN = 9;
	localparam int CTEN_POS_TOGGLE = 10;
	localparam int CTEN_POS_BPS = 11;
	localparam int CTEN_POS_EDGE = 13;
	localparam int CTEN_POS_CHDIR = 14;
	localparam int CTEN_POS_RDIR = 15;

	// Aux register: remote run selects and zero-clear enable
	localparam int CTEN_POS_AUXA_RC = 0;
	localparam int CTEN_POS_AUXB_RC = 1;
	localparam int CTEN_POS_ZCLR = 2;

	// ========================================================================
	// Reset values
	localparam logic [15:0] CTEN_RST_CONTROL = 16'h0000;
	localparam logic [15:0] CTEN_RST_COUNT = 16'h0000;
	localparam logic [2:0] CTEN_RST_AUX = 3'h0;

	// ========================================================================
	// Mode encodings
	localparam logic [2:0] CTEN_MODE_TIMER = 3'h0;
	localparam logic [2:0] CTEN_MODE_COUNTER = 3'h1;
	localparam logic [2:0] CTEN_MODE_GATE_LO = 3'h2;
	localparam logic [2:0] CTEN_MODE_GATE_HI = 3'h3;
	localparam logic [2:0] CTEN_MODE_ENC_ROT = 3'h6;
	localparam logic [2:0] CTEN_MODE_ENC_EDGE = 3'h7;

	// Base prescale: 4 << (bps + insel) module clocks per step
	localparam logic [3:0] CTEN_PRE_BASE_SHIFT = 4'h2;

	// ========================================================================
	// APB request carrier
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} cten_apb_req_t;

	// Auxiliary-timer facing outputs
	typedef struct packed {
		logic toggle;
		logic shadow;
		logic auxARun;
		logic auxBRun;
	} cten_aux_t;

endpackage : cten_pkg

//--- cten_core_timer.sv
// Core timer with gated, counter and quadrature encoder modes behind an APB slave
`timescale 1ns/1ps

// Behaviour
// - Core timer counts only while the run bit is set, in every mode.
// - Count register is readable and writable by software at any time.
// - Remote run select lets the core run bit start and stop an aux timer.
// - Without external direction enable, direction follows the software bit only.
// - With external enable, up/down pin sets direction; software bit inverts it.
// - Direction changes take effect whether running or stopped.
// - Overflow or underflow toggles latch; shadow follows one clock later.
// - Software write to toggle bit loads latch and shadow together.
// - Toggle pin shows latch when output enabled, otherwise constant high.
// - Mode 000 counts prescaled module clock, prescale from base, bps and input select.
// - Modes 010 and 011 gate counting on input pin low or high.
// - Gated mode advances only when run bit set and gate active.
// - Gate input transitions never raise an interrupt request.
// - Mode 001 steps on selected rising, falling or both input edges.
// - Modes 110 and 111 count quadrature edges on one or both inputs.
// - Encoder direction comes from edge sequence per the quadrature table.
// - Mode 110 raises an interrupt request on each direction change.
// - Mode 111 raises an interrupt request on each count edge.
// - Control register shows rotation direction, direction change and count edge flags.
// - Zero pulse on aux-B input pin can clear the count without software, in modes 110 and 111 only.
// - Software write to count wins over a same-cycle count step.
module cten_core_timer
	import cten_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic coreInputPin,
	input wire logic coreUpdownPin,
	input wire logic auxBInputPin,
	output logic toggleOutputPin,
	output logic coreInterruptRequest,
	output cten_aux_t auxOut
);

	// ========================================================================
	// Bus decode
	cten_apb_req_t req;
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	wire logic accessCyc = req.sel & req.enable;
	// Commit only on the edge that ends the access, so a write lands exactly once
	wire logic commitCyc = accessCyc & pready;
	wire logic hitCtrl = req.addr == CTEN_OFF_CONTROL;
	wire logic hitCount = req.addr == CTEN_OFF_COUNT;
	wire logic hitAux = req.addr == CTEN_OFF_AUX;
	wire logic hitAny = hitCtrl | hitCount | hitAux;
	wire logic wrCtrl = commitCyc & req.write & hitCtrl;
	wire logic wrCount = commitCyc & req.write & hitCount;
	wire logic wrAux = commitCyc & req.write & hitAux;

	// ========================================================================
	// Registers
	logic [15:0] ctrl_ff;
	logic [15:0] count_ff;
	logic [2:0] aux_ff;
	logic toggle_ff;
	logic shadow_ff;
	logic [15:0] pre_ff;
	logic [2:0] inSync1_ff;
	logic [2:0] inSync2_ff;
	logic [2:0] inPrev_ff;
	logic lastDir_ff;
	logic dirKnown_ff;

	wire logic [2:0] insel = ctrl_ff[CTEN_POS_INSEL +: 3];
	wire logic [2:0] mode = ctrl_ff[CTEN_POS_MODE +: 3];
	wire logic runBit = ctrl_ff[CTEN_POS_RUN];
	wire logic swDir = ctrl_ff[CTEN_POS_SWDIR];
	wire logic extDirEn = ctrl_ff[CTEN_POS_EXTDIR];
	wire logic outEn = ctrl_ff[CTEN_POS_OUTEN];
	wire logic [1:0] bps = ctrl_ff[CTEN_POS_BPS +: 2];

	// ========================================================================
	// Input synchronisers, two stages then one history stage
	// sampled inputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			inSync1_ff <= 3'h0;
			inSync2_ff <= 3'h0;
			inPrev_ff <= 3'h0;
		end else begin
			inSync1_ff <= {auxBInputPin, coreUpdownPin, coreInputPin};
			inSync2_ff <= inSync1_ff;
			inPrev_ff <= inSync2_ff;
		end
	end

	wire logic inA = inSync2_ff[0];
	wire logic inB = inSync2_ff[1];
	wire logic riseA = inA & ~inPrev_ff[0];
	wire logic fallA = ~inA & inPrev_ff[0];
	wire logic riseB = inB & ~inPrev_ff[1];
	wire logic fallB = ~inB & inPrev_ff[1];
	wire logic zeroPulse = aux_ff[CTEN_POS_ZCLR] & inSync2_ff[2] & ~inPrev_ff[2];

	// ========================================================================
	// Prescaler: free-running divider, tick when masked bits wrap
	// cascaded prescale
	wire logic [3:0] preShift = CTEN_PRE_BASE_SHIFT + 4'(bps) + 4'(insel);
	wire logic [15:0] preMask = 16'((17'h00001 << preShift) - 17'h00001);
	wire logic preTick = (pre_ff & preMask) == preMask;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_ff <= 16'h0000;
		end else begin
			pre_ff <= pre_ff + 16'h0001;
		end
	end

	// ========================================================================
	// Mode decode and count enable
	wire logic isTimer = mode == CTEN_MODE_TIMER;
	wire logic isCounter = mode == CTEN_MODE_COUNTER;
	wire logic isGated = (mode == CTEN_MODE_GATE_LO) | (mode == CTEN_MODE_GATE_HI);
	wire logic isEnc = (mode == CTEN_MODE_ENC_ROT) | (mode == CTEN_MODE_ENC_EDGE);
	// gate polarity from low mode bit
	wire logic gateActive = inA == mode[0];

	wire logic cntEdge = (insel[0] & riseA) | (insel[1] & fallA);

	wire logic encEdgeA = (riseA | fallA) & (insel[0] | insel == 3'h0);
	wire logic encEdgeB = (riseB | fallB) & (insel[1] | insel == 3'h0);
	wire logic encEdge = encEdgeA | encEdgeB;
	wire logic encDownA = riseA ? inB : ~inB;
	wire logic encDownB = riseB ? ~inA : inA;
	wire logic encDown = encEdgeA ? encDownA : encDownB;

	// software or pin direction, software bit inverts
	wire logic pinDown = extDirEn ? inB : 1'b0;
	// direction is combinational, valid even when stopped
	wire logic stepDown = isEnc ? encDown : (pinDown ^ swDir);

	wire logic step = runBit & ((isTimer & preTick) | (isGated & gateActive & preTick)
		| (isCounter & cntEdge) | (isEnc & encEdge));

	wire logic wrapUp = step & ~stepDown & (count_ff == 16'hffff);
	wire logic wrapDown = step & stepDown & (count_ff == 16'h0000);

	// ========================================================================
	// Count register
	wire logic [15:0] stepped = stepDown ? count_ff - 16'h0001 : count_ff + 16'h0001;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_ff <= CTEN_RST_COUNT;
		end else if (wrCount) begin
			count_ff <= req.wdata[15:0];
		end else if (zeroPulse & isEnc) begin
			count_ff <= 16'h0000;
		end else if (step) begin
			count_ff <= stepped;
		end
	end

	// ========================================================================
	// Toggle latch and shadow
	// software loads both together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			toggle_ff <= 1'b0;
			shadow_ff <= 1'b0;
		end else if (wrCtrl) begin
			toggle_ff <= req.wdata[CTEN_POS_TOGGLE];
			shadow_ff <= req.wdata[CTEN_POS_TOGGLE];
		end else begin
			toggle_ff <= toggle_ff ^ (wrapUp | wrapDown);
			shadow_ff <= toggle_ff;
		end
	end

	// ========================================================================
	// Encoder status: direction, change and edge flags
	logic rdir_ff;
	logic chdir_ff;
	logic edge_ff;
	wire logic encCount = runBit & isEnc & encEdge;
	wire logic dirChange = encCount & dirKnown_ff & (encDown != lastDir_ff);

	// status flags, hardware set wins over software clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdir_ff <= 1'b0;
			chdir_ff <= 1'b0;
			edge_ff <= 1'b0;
			lastDir_ff <= 1'b0;
			dirKnown_ff <= 1'b0;
		end else begin
			rdir_ff <= encCount ? encDown : rdir_ff;
			chdir_ff <= dirChange | (chdir_ff & ~(wrCtrl & ~req.wdata[CTEN_POS_CHDIR]));
			edge_ff <= encCount | (edge_ff & ~(wrCtrl & ~req.wdata[CTEN_POS_EDGE]));
			lastDir_ff <= encCount ? encDown : lastDir_ff;
			dirKnown_ff <= dirKnown_ff | encCount;
		end
	end

	// ========================================================================
	// Control and aux registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_ff <= CTEN_RST_CONTROL;
			aux_ff <= CTEN_RST_AUX;
		end else begin
			if (wrCtrl) begin
				ctrl_ff <= req.wdata[15:0];
			end
			if (wrAux) begin
				aux_ff <= req.wdata[2:0];
			end
		end
	end

	// ========================================================================
	// Interrupt request, one-cycle pulse
	// direction change in rotation mode
	wire logic nxt_irq = (mode == CTEN_MODE_ENC_ROT & dirChange)
		| (mode == CTEN_MODE_ENC_EDGE & encCount);

	// ========================================================================
	// Read data and registered outputs
	wire logic [15:0] ctrlView = {rdir_ff, chdir_ff, edge_ff, ctrl_ff[12:11], toggle_ff,
		ctrl_ff[9:0]};
	wire logic [31:0] nxt_prdata = !hitAny ? 32'h00000000
		: hitCtrl ? {16'h0000, ctrlView}
		: hitCount ? {16'h0000, count_ff}
		: {29'h00000000, aux_ff};
	// Ready one cycle into the access phase, so every access takes exactly one wait
	wire logic nxt_pready = accessCyc & ~pready;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			toggleOutputPin <= 1'b1;
			coreInterruptRequest <= 1'b0;
			auxOut <= '0;
		end else begin
			prdata <= nxt_prdata;
			pready <= nxt_pready;
			pslverr <= nxt_pready & ~hitAny;
			toggleOutputPin <= outEn ? toggle_ff : 1'b1;
			coreInterruptRequest <= nxt_irq;
			auxOut <= '{toggle: toggle_ff, shadow: shadow_ff,
				auxARun: runBit & aux_ff[CTEN_POS_AUXA_RC],
				auxBRun: runBit & aux_ff[CTEN_POS_AUXB_RC]};
		end
	end

endmodule : cten_core_timer

//--- cten_checker.sv
// Port-level assertions for the core timer block
`timescale 1ns/1ps
module cten_checker
	import cten_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic coreInputPin,
	input wire logic coreUpdownPin,
	input wire logic auxBInputPin,
	input wire logic toggleOutputPin,
	input wire logic coreInterruptRequest,
	input wire cten_aux_t auxOut
);
	// ========================================================================
	// Helpers: decodes and a short pin-edge history
	logic prevA_ff;
	logic prevB_ff;
	logic [5:0] chg_ff;
	wire ctlWr = psel && penable && pready && pwrite && (paddr == CTEN_OFF_CONTROL);
	wire cfgWr = ctlWr || (psel && penable && pready && pwrite && (paddr == CTEN_OFF_AUX));
	wire mapped = paddr inside {CTEN_OFF_CONTROL, CTEN_OFF_COUNT, CTEN_OFF_AUX};
	wire pinChg = (prevA_ff != coreInputPin) || (prevB_ff != coreUpdownPin);
	// History window covers the synchroniser latency
	always_ff @(posedge clk) begin
		prevA_ff <= coreInputPin;
		prevB_ff <= coreUpdownPin;
		chg_ff <= rst_n ? {chg_ff[4:0], pinChg} : 6'h00;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ========================================================================
	// Assertions
	apb_wait_a: assert property (psel && !penable |-> !pready ##1 !pready ##1 pready)
		else $error("pready not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	err_cause_a: assert property (pslverr |-> pready && !mapped)
		else $error("spurious pslverr");
	shadow_follow_a: assert property (!$past(ctlWr) && !$past(ctlWr, 2) |-> auxOut.shadow == $past(auxOut.toggle))
		else $error("shadow does not trail latch");
	sw_toggle_a: assert property ($past(ctlWr, 2) |-> auxOut.toggle == $past(pwdata[CTEN_POS_TOGGLE], 2) && auxOut.shadow == auxOut.toggle)
		else $error("toggle write left latches apart");
	toggle_pin_a: assert property (!toggleOutputPin |-> !auxOut.toggle)
		else $error("toggle pin low with latch high");
	aux_run_a: assert property ($changed(auxOut.auxARun) || $changed(auxOut.auxBRun) |-> $past(cfgWr) || $past(cfgWr, 2))
		else $error("aux run moved without a write");
	irq_cause_a: assert property (coreInterruptRequest |-> |chg_ff[5:1])
		else $error("interrupt without pin edge");
	irq_pulse_a: assert property (coreInterruptRequest |=> !coreInterruptRequest)
		else $error("interrupt longer than one cycle");
endmodule : cten_checker

bind cten_core_timer cten_checker chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .coreInputPin(coreInputPin),
	.coreUpdownPin(coreUpdownPin), .auxBInputPin(auxBInputPin),
	.toggleOutputPin(toggleOutputPin), .coreInterruptRequest(coreInterruptRequest),
	.auxOut(auxOut));

//--- cten_enc_model.sv
// Behavioural quadrature encoder with zero-mark output
`timescale 1ns/1ps
module cten_enc_model (
	input wire logic clk,
	input wire logic stepA,
	input wire logic stepB,
	input wire logic zeroReq,
	output logic pinA,
	output logic pinB,
	output logic pinZ
);
	// ========================================================================
	// Channels always driven, so they hold their level between steps
	logic a_ff = 1'b0;
	logic b_ff = 1'b0;
	logic z_ff = 1'b0;
	always @(posedge clk) begin
		a_ff <= a_ff ^ stepA;
		b_ff <= b_ff ^ stepB;
		z_ff <= zeroReq;
	end
	assign pinA = a_ff;
	assign pinB = b_ff;
	assign pinZ = z_ff;
endmodule : cten_enc_model

//--- cten_tb.sv
// Self-checking bench for the core timer block
`timescale 1ns/1ps
module testbench;
	import cten_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic stepA = 1'b0;
	logic stepB = 1'b0;
	logic zeroReq = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, pinA, pinB, pinZ, togPin, irq, err;
	cten_aux_t aux;
	int n_errors = 0;
	int total_checks = 0;
	int nIrq = 0;
	// ========================================================================
	// Design, encoder and clock
	cten_core_timer dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .coreInputPin(pinA), .coreUpdownPin(pinB), .auxBInputPin(pinZ),
		.toggleOutputPin(togPin), .coreInterruptRequest(irq), .auxOut(aux));
	cten_enc_model enc_u (.clk(clk), .stepA(stepA), .stepB(stepB), .zeroReq(zeroReq),
		.pinA(pinA), .pinB(pinB), .pinZ(pinZ));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) if (irq === 1'b1) nIrq++;
	// ========================================================================
	// Shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// APB cycle; waits for pready, only the watchdog bounds the wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Flags f = {toggle, out enable, ext dir, sw dir, run}
	function automatic logic [31:0] ctl(input logic [2:0] m, input logic [2:0] i, input logic [4:0] f);
		return 32'({f, m, i});
	endfunction : ctl
	// steps spaced well below the count rate
	task automatic tgl(input logic a, input logic b);
		stepA <= a;
		stepB <= b;
		@(posedge clk);
		stepA <= 1'b0;
		stepB <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : tgl
	// ========================================================================
	// Scenarios
	task automatic t_reset;
		chk(32'(togPin), 32'h1);
		apb(1'b0, CTEN_OFF_CONTROL, 32'h0);
		chk(rd, 32'(CTEN_RST_CONTROL));
		apb(1'b0, 8'h0c, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, CTEN_OFF_COUNT, 32'h1234_abcd);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(rd, 32'h0000_abcd);
	endtask : t_reset
	task automatic t_timer;
		apb(1'b1, CTEN_OFF_COUNT, 32'h2);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h03));
		repeat (40) @(posedge clk);
		// Looked at before the stop write, which reloads the latch
		chk(32'({aux.toggle, aux.shadow, togPin}), 32'h7);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h02));
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(32'(rd[15:8]), 32'hff);
		apb(1'b1, CTEN_OFF_COUNT, 32'h0100);
		repeat (20) @(posedge clk);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(rd, 32'h0100);
		// Direction flipped while running: a few steps down, then many up
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h03));
		repeat (8) @(posedge clk);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h01));
		repeat (60) @(posedge clk);
		apb(1'b1, CTEN_OFF_CONTROL, 32'h0);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(32'(rd[15:0] > 16'h0100 && rd[15:0] < 16'h0120), 32'h1);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h18));
		repeat (3) @(posedge clk);
		chk(32'({aux.toggle, aux.shadow, togPin}), 32'h7);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h08));
		repeat (3) @(posedge clk);
		chk(32'({aux.toggle, aux.shadow, togPin}), 32'h0);
	endtask : t_timer
	task automatic t_counter;
		logic [2:0] sel [5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3};
		logic [4:0] fl [5] = '{5'h01, 5'h01, 5'h01, 5'h05, 5'h07};
		logic [31:0] ex [5] = '{32'h2, 32'h2, 32'h4, 32'hfffc, 32'h4};
		for (int j = 0; j < 5; j++) begin
			if (j == 3) tgl(1'b0, 1'b1);
			apb(1'b1, CTEN_OFF_COUNT, 32'h0);
			apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_COUNTER, sel[j], fl[j]));
			repeat (4) tgl(1'b1, 1'b0);
			apb(1'b1, CTEN_OFF_CONTROL, 32'h0);
			apb(1'b0, CTEN_OFF_COUNT, 32'h0);
			chk(rd, ex[j]);
		end
		repeat (2) tgl(1'b1, 1'b0);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(rd, 32'h4);
	endtask : t_counter
	task automatic t_gate;
		nIrq = 0;
		apb(1'b1, CTEN_OFF_COUNT, 32'h0);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_GATE_HI, 3'h0, 5'h01));
		repeat (30) @(posedge clk);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_GATE_LO, 3'h0, 5'h00));
		repeat (30) @(posedge clk);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_GATE_LO, 3'h0, 5'h01));
		repeat (2) tgl(1'b1, 1'b0);
		apb(1'b1, CTEN_OFF_CONTROL, 32'h0);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(32'(rd != 32'h0 && nIrq == 0), 32'h1);
	endtask : t_gate
	task automatic t_encoder;
		tgl(1'b0, 1'b1);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_ENC_EDGE, 3'h0, 5'h04));
		apb(1'b1, CTEN_OFF_COUNT, 32'h0);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_ENC_EDGE, 3'h0, 5'h05));
		nIrq = 0;
		repeat (2) begin
			tgl(1'b1, 1'b0);
			tgl(1'b0, 1'b1);
		end
		tgl(1'b0, 1'b1);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(rd, 32'h3);
		chk(32'(nIrq), 32'h5);
		apb(1'b0, CTEN_OFF_CONTROL, 32'h0);
		chk(32'(rd[15:13]), 32'h7);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_ENC_ROT, 3'h0, 5'h05));
		nIrq = 0;
		tgl(1'b0, 1'b1);
		tgl(1'b0, 1'b1);
		tgl(1'b1, 1'b0);
		chk(32'(nIrq), 32'h2);
	endtask : t_encoder
	task automatic t_aux;
		apb(1'b1, CTEN_OFF_AUX, 32'h4);
		zeroReq <= 1'b1;
		repeat (2) @(posedge clk);
		zeroReq <= 1'b0;
		repeat (8) @(posedge clk);
		apb(1'b0, CTEN_OFF_COUNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, CTEN_OFF_AUX, 32'h1);
		apb(1'b1, CTEN_OFF_CONTROL, ctl(CTEN_MODE_TIMER, 3'h0, 5'h01));
		// Run outputs are registered one edge behind the control write
		@(posedge clk);
		chk(32'({aux.auxARun, aux.auxBRun}), 32'h2);
		apb(1'b1, CTEN_OFF_CONTROL, 32'h0);
		@(posedge clk);
		chk(32'({aux.auxARun, aux.auxBRun}), 32'h0);
	endtask : t_aux
	// ========================================================================
	// Verdict, watchdog and main sequence
	task automatic final_report;
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_timer();
		t_counter();
		t_gate();
		t_encoder();
		t_aux();
		final_report();
	end
endmodule : testbench
